/* File: common/fpc_params.svh */
// timing counts and command codes for the feature pin control block
// assumes a single 125 MHz system clock and no software-visible registers
//
// Overview of operation
// - grounded write-protect pin enables write protection
// - erase starts after trigger low 0.8 s
// - activity LED on during host link access
// - erase LED blinks while erase runs
// - LED outputs driven high active, low idle
// - power-connector activity: drive low, else float
// - F1, F3, F4 command sequence also erases
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define FPC_CLK_KHZ          125000
`define FPC_ERASE_HOLD_MS    800
`define FPC_ERASE_HOLD_CYC   (`FPC_ERASE_HOLD_MS * `FPC_CLK_KHZ)
`define FPC_BLINK_HALF_MS    250
`define FPC_BLINK_HALF_CYC   (`FPC_BLINK_HALF_MS * `FPC_CLK_KHZ)
`define FPC_ACT_STRETCH_MS   20
`define FPC_ACT_STRETCH_CYC  (`FPC_ACT_STRETCH_MS * `FPC_CLK_KHZ)
`define FPC_CNT_W            27

// ----------------------------------------------------------------------
// security command codes and pin indices
// ----------------------------------------------------------------------
`define FPC_CMD_SET_PW       8'hF1
`define FPC_CMD_ERASE_PREP   8'hF3
`define FPC_CMD_ERASE_UNIT   8'hF4
`define FPC_PIN_WP           0
`define FPC_PIN_TRIG         1
`define FPC_PIN_RESET_VAL    2'h3

`endif

/* File: common/fpc_pkg.sv */
// types shared by the feature pin control modules
// assumes fpc_params.svh supplies the counter width
`include "fpc_params.svh"

package fpc_pkg;

  // main erase state, one-hot
  typedef enum logic [1:0] {
    FPC_ST_IDLE  = 2'b01,
    FPC_ST_ERASE = 2'b10
  } fpc_state_e;

  // progress through the security command sequence, one-hot
  typedef enum logic [2:0] {
    FPC_SEQ_NONE = 3'b001,
    FPC_SEQ_PW   = 3'b010,
    FPC_SEQ_PREP = 3'b100
  } fpc_seq_e;

  typedef logic [`FPC_CNT_W-1:0] fpc_cnt_t;

endpackage

/* File: common/fpc_sync_if.sv */
// raw and synchronised low-active feature pins between top and synchroniser
// assumes both ends sit in the sys_clk domain
interface fpc_sync_if;
  logic [1:0] raw_n;
  logic [1:0] sync_n;

  modport filt (input raw_n, output sync_n);
  modport user (output raw_n, input sync_n);
endinterface

/* File: design/fpc_pin_sync.sv */
// two-stage synchronisers for the low-active feature inputs
// assumes the pins are quasi-static switches, sampled on sys_clk
module fpc_pin_sync (
  // clock and reset
  input wire logic   sys_clk,
  input wire logic   rst_n,
  // pins
  fpc_sync_if.filt   pins
);

  logic [1:0] meta;
  logic [1:0] stable;

  // ----------------------------------------------------------------------
  // one synchroniser per pin
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      // reset to released so nothing fires at power-up
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta[gi]   <= 1'b1;
          stable[gi] <= 1'b1;
        end else begin
          meta[gi]   <= pins.raw_n[gi];
          stable[gi] <= meta[gi];
        end
      end
    end
  endgenerate

  assign pins.sync_n = stable;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_sync_delay;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n, 2) |-> pins.sync_n == $past(pins.raw_n, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("pin sync latency not two cycles");

endmodule

/* File: design/fpc_top.sv */
// feature pin control: write protect, hardware erase trigger, activity LEDs
// assumes switches to ground on inputs, LEDs to ground on outputs, one clock
`include "fpc_params.svh"

module fpc_top #(
  parameter int unsigned ERASE_HOLD_CYC  = `FPC_ERASE_HOLD_CYC,
  parameter int unsigned BLINK_HALF_CYC  = `FPC_BLINK_HALF_CYC,
  parameter int unsigned ACT_STRETCH_CYC = `FPC_ACT_STRETCH_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // feature connector inputs, low active
  input  wire logic       wp_pin_n,
  input  wire logic       erase_trig_n,
  // host link events from the controller
  input  wire logic       link_access,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_code,
  // erase engine handshake
  output logic            erase_start,
  input  wire logic       erase_done,
  output logic            erase_busy,
  // drive state
  output logic            write_protect,
  // indicator outputs
  output logic            dev_act_led,
  output logic            erase_led,
  // power connector activity, open drain
  output logic            pwr_act_o,
  output logic            pwr_act_oe_n
);

  fpc_sync_if            sync_bus ();
  fpc_pkg::fpc_state_e   state;
  fpc_pkg::fpc_seq_e     seq;
  fpc_pkg::fpc_cnt_t     hold_cnt;
  fpc_pkg::fpc_cnt_t     blink_cnt;
  fpc_pkg::fpc_cnt_t     act_cnt;
  logic                  trig_low;
  logic                  trig_armed;
  logic                  pin_start;
  logic                  cmd_start;
  logic                  hold_done;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  assign sync_bus.raw_n = {erase_trig_n, wp_pin_n};

  fpc_pin_sync u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pins    (sync_bus.filt)
  );

  assign trig_low = !sync_bus.sync_n[`FPC_PIN_TRIG];

  // ----------------------------------------------------------------------
  // write protection
  // ----------------------------------------------------------------------
  // level follows the pin; no latching so the switch can be released
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_protect <= 1'b0;
    end else begin
      write_protect <= !sync_bus.sync_n[`FPC_PIN_WP];
    end
  end

  // ----------------------------------------------------------------------
  // erase trigger hold timer
  // ----------------------------------------------------------------------
  assign hold_done = (hold_cnt == fpc_pkg::fpc_cnt_t'(ERASE_HOLD_CYC - 1));

  // any glitch high restarts the count from zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= '0;
    end else if (!trig_low || hold_done) begin
      hold_cnt <= '0;
    end else begin
      hold_cnt <= hold_cnt + fpc_pkg::fpc_cnt_t'(1);
    end
  end

  // switch must be released before the next erase, else a held
  // switch would start a new erase each time the last one ends
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_armed <= 1'b1;
    end else if (!trig_low) begin
      trig_armed <= 1'b1;
    end else if (hold_done) begin
      trig_armed <= 1'b0;
    end
  end

  assign pin_start = trig_low && hold_done && trig_armed
                     && (state == fpc_pkg::FPC_ST_IDLE);

  // ----------------------------------------------------------------------
  // security command sequence tracker
  // ----------------------------------------------------------------------
  // any other command in between breaks the sequence
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq <= fpc_pkg::FPC_SEQ_NONE;
    end else if (cmd_valid) begin
      if (cmd_code == `FPC_CMD_SET_PW) begin
        seq <= fpc_pkg::FPC_SEQ_PW;
      end else if (cmd_code == `FPC_CMD_ERASE_PREP && seq == fpc_pkg::FPC_SEQ_PW) begin
        seq <= fpc_pkg::FPC_SEQ_PREP;
      end else begin
        seq <= fpc_pkg::FPC_SEQ_NONE;
      end
    end
  end

  assign cmd_start = cmd_valid && (cmd_code == `FPC_CMD_ERASE_UNIT)
                     && (seq == fpc_pkg::FPC_SEQ_PREP)
                     && (state == fpc_pkg::FPC_ST_IDLE);

  // ----------------------------------------------------------------------
  // erase state machine
  // ----------------------------------------------------------------------
  // both sources lead to the same erase and the same indication
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= fpc_pkg::FPC_ST_IDLE;
      erase_start <= 1'b0;
    end else begin
      erase_start <= 1'b0;
      unique case (state)
        fpc_pkg::FPC_ST_IDLE: begin
          if (pin_start || cmd_start) begin
            state       <= fpc_pkg::FPC_ST_ERASE;
            erase_start <= 1'b1;
          end
        end
        fpc_pkg::FPC_ST_ERASE: begin
          if (erase_done) begin
            state <= fpc_pkg::FPC_ST_IDLE;
          end
        end
      endcase
    end
  end

  assign erase_busy = (state == fpc_pkg::FPC_ST_ERASE);

  // ----------------------------------------------------------------------
  // erase activity blink
  // ----------------------------------------------------------------------
  // lamp goes on at once when erase starts and off when it ends
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt <= '0;
      erase_led <= 1'b0;
    end else if (state != fpc_pkg::FPC_ST_ERASE) begin
      blink_cnt <= '0;
      erase_led <= pin_start || cmd_start;
    end else if (erase_done) begin
      blink_cnt <= '0;
      erase_led <= 1'b0;
    end else if (blink_cnt == fpc_pkg::fpc_cnt_t'(BLINK_HALF_CYC - 1)) begin
      blink_cnt <= '0;
      erase_led <= !erase_led;
    end else begin
      blink_cnt <= blink_cnt + fpc_pkg::fpc_cnt_t'(1);
    end
  end

  // ----------------------------------------------------------------------
  // device activity indication
  // ----------------------------------------------------------------------
  // single-cycle accesses are stretched so a lamp is visible at all
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_cnt     <= '0;
      dev_act_led <= 1'b0;
    end else if (link_access) begin
      act_cnt     <= fpc_pkg::fpc_cnt_t'(ACT_STRETCH_CYC - 1);
      dev_act_led <= 1'b1;
    end else if (act_cnt != '0) begin
      act_cnt     <= act_cnt - fpc_pkg::fpc_cnt_t'(1);
    end else begin
      dev_act_led <= 1'b0;
    end
  end

  // power connector pin only ever pulls low; no pull-up inside
  assign pwr_act_o    = 1'b0;
  assign pwr_act_oe_n = !dev_act_led;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  int unsigned low_run;

  // consecutive synchronised low cycles, independent of hold_cnt;
  // saturates at the hold count so it never wraps on a stuck switch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_run <= 0;
    end else if (!trig_low) begin
      low_run <= 0;
    end else if (low_run < ERASE_HOLD_CYC) begin
      low_run <= low_run + 1;
    end
  end

  property p_wp_follow;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n, 3) |-> write_protect == !$past(wp_pin_n, 3);
  endproperty
  a_wp_follow: assert property (p_wp_follow) else $error("write protect not tracking pin");

  property p_hold_min;
    @(posedge sys_clk) disable iff (!rst_n)
      pin_start |-> low_run == ERASE_HOLD_CYC - 1;
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("pin erase started before hold time");

  property p_hold_restart;
    @(posedge sys_clk) disable iff (!rst_n)
      !trig_low |=> hold_cnt == '0;
  endproperty
  a_hold_restart: assert property (p_hold_restart) else $error("hold timer not restarted");

  property p_act_on;
    @(posedge sys_clk) disable iff (!rst_n)
      link_access |=> dev_act_led && !pwr_act_oe_n;
  endproperty
  a_act_on: assert property (p_act_on) else $error("activity indicator missed access");

  property p_blink;
    @(posedge sys_clk) disable iff (!rst_n)
      erase_busy && !erase_done && blink_cnt == fpc_pkg::fpc_cnt_t'(BLINK_HALF_CYC - 1)
        |=> erase_led != $past(erase_led);
  endproperty
  a_blink: assert property (p_blink) else $error("erase lamp did not toggle");

  property p_idle_low;
    @(posedge sys_clk) disable iff (!rst_n)
      !erase_busy && !$past(erase_busy) |-> !erase_led;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("erase lamp lit while idle");

  property p_pwr_od;
    @(posedge sys_clk) disable iff (!rst_n)
      !pwr_act_o && (pwr_act_oe_n == !dev_act_led);
  endproperty
  a_pwr_od: assert property (p_pwr_od) else $error("power activity pin driven wrongly");

  // back-to-back strobes only: a gap window would also accept foreign
  // commands in between, which break the sequence and must not erase
  property p_cmd_erase;
    @(posedge sys_clk) disable iff (!rst_n)
      cmd_valid && cmd_code == `FPC_CMD_SET_PW
      ##1 cmd_valid && cmd_code == `FPC_CMD_ERASE_PREP
      ##1 cmd_valid && cmd_code == `FPC_CMD_ERASE_UNIT && !erase_busy
      |=> erase_busy && erase_start;
  endproperty
  a_cmd_erase: assert property (p_cmd_erase) else $error("command sequence did not erase");

endmodule

/* File: sim/fpc_board_model.sv */
// board side of the feature pins: two switches to ground and two lamps
// assumes the switch pins float high when open and the activity line has a board pull-up
module fpc_board_model (
  // clock for the lamp watcher
  input  wire logic sys_clk,
  // switch controls from the bench
  input  wire logic wp_close,
  input  wire logic trig_close,
  // switch pins toward the device
  output logic      wp_pin_n,
  output logic      erase_trig_n,
  // lamps and power connector line from the device
  input  wire logic dev_act_led,
  input  wire logic erase_led,
  input  wire logic pwr_act_o,
  input  wire logic pwr_act_oe_n,
  output logic      pwr_act_line,
  output int        flips
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_led;

  // a closed switch grounds the pin, an open one is pulled high
  assign wp_pin_n     = wp_close ? 1'b0 : 1'b1;
  assign erase_trig_n = trig_close ? 1'b0 : 1'b1;

  // released line rises through the board resistor, never the last driven value
  assign pwr_act_line = pwr_act_oe_n ? 1'b1 : pwr_act_o;

  // count every lamp change so the bench can judge the blink rate
  initial begin
    flips    = 0;
    last_led = 1'b0;
  end
  always @(posedge sys_clk) begin
    if (erase_led !== last_led) begin
      flips = flips + 1;
    end
    last_led = erase_led;
  end
endmodule

/* File: sim/tb.sv */
// bench for the feature pin control block, one task per scenario
// assumes short counts via parameters and the board model on the pins
`include "fpc_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  localparam int HALF = 4;
  localparam int STR  = 3;

  logic       sys_clk, rst_n, wp_close, trig_close, link_access, cmd_valid, erase_done;
  logic [7:0] cmd_code;
  logic       wp_pin_n, erase_trig_n, erase_start, erase_busy, write_protect;
  logic       dev_act_led, erase_led, pwr_act_o, pwr_act_oe_n, pwr_act_line;
  int         flips, starts, mismatches, checks_done, n, s0, f0;

  fpc_top #(.ERASE_HOLD_CYC(HOLD), .BLINK_HALF_CYC(HALF), .ACT_STRETCH_CYC(STR)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .wp_pin_n(wp_pin_n), .erase_trig_n(erase_trig_n),
    .link_access(link_access), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .erase_start(erase_start), .erase_done(erase_done), .erase_busy(erase_busy),
    .write_protect(write_protect), .dev_act_led(dev_act_led), .erase_led(erase_led),
    .pwr_act_o(pwr_act_o), .pwr_act_oe_n(pwr_act_oe_n));

  fpc_board_model u_board (
    .sys_clk(sys_clk), .wp_close(wp_close), .trig_close(trig_close), .wp_pin_n(wp_pin_n),
    .erase_trig_n(erase_trig_n), .dev_act_led(dev_act_led), .erase_led(erase_led),
    .pwr_act_o(pwr_act_o), .pwr_act_oe_n(pwr_act_oe_n), .pwr_act_line(pwr_act_line), .flips(flips));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // start pulses are counted so a missed or extra erase shows up later
  always @(posedge sys_clk) begin
    if (erase_start === 1'b1) begin
      starts++;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s saw %0h want %0h", $time, msg, seen, exp);
    end
  endtask

  // settle just past the edge so registered outputs have landed
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_start(input int lim);
    n = 0;
    while (erase_start !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic send(input logic [7:0] c);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
  endtask

  task automatic idle;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask

  task automatic finish_erase;
    @(posedge sys_clk);
    erase_done <= 1'b1;
    @(posedge sys_clk);
    erase_done <= 1'b0;
    cyc(1);
    chk(erase_busy, 0, "busy after done");
    chk(erase_led, 0, "lamp idle low");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_wp;
    @(posedge sys_clk);
    wp_close <= 1'b1;
    cyc(2);
    chk(write_protect, 0, "protect before sync");
    cyc(1);
    chk(write_protect, 1, "protect on ground");
    @(posedge sys_clk);
    wp_close <= 1'b0;
    cyc(3);
    chk(write_protect, 0, "protect off open");
    $display("test wp done");
  endtask

  // two short holds whose sum exceeds the minimum must not erase
  task automatic t_trig_short;
    s0 = starts;
    repeat (2) begin
      @(posedge sys_clk);
      trig_close <= 1'b1;
      cyc(HOLD - 4);
      @(posedge sys_clk);
      trig_close <= 1'b0;
      cyc(3);
    end
    chk(starts, s0, "short holds");
    $display("test trig_short done");
  endtask

  task automatic t_trig_long;
    s0 = starts;
    @(posedge sys_clk);
    trig_close <= 1'b1;
    wait_start(HOLD + 10);
    chk(32'(n >= HOLD && n <= HOLD + 3), 1, "hold time");
    chk(erase_busy, 1, "busy at start");
    f0 = flips;
    cyc(4 * HALF);
    chk(flips - f0, 4, "blink count");
    finish_erase();
    cyc(HOLD + 5);
    chk(starts, s0 + 1, "held pin no restart");
    @(posedge sys_clk);
    trig_close <= 1'b0;
    cyc(3);
    $display("test trig_long done");
  endtask

  task automatic t_cmd;
    s0 = starts;
    send(`FPC_CMD_SET_PW);
    send(8'h00);
    send(`FPC_CMD_ERASE_PREP);
    send(`FPC_CMD_ERASE_UNIT);
    idle();
    cyc(2);
    chk(starts, s0, "broken sequence");
    send(`FPC_CMD_SET_PW);
    send(`FPC_CMD_ERASE_PREP);
    send(`FPC_CMD_ERASE_UNIT);
    idle();
    chk(erase_start, 1, "command erase");
    chk(erase_led, 1, "lamp lit");
    finish_erase();
    $display("test cmd done");
  endtask

  task automatic t_act;
    @(posedge sys_clk);
    link_access <= 1'b1;
    @(posedge sys_clk);
    link_access <= 1'b0;
    #1;
    chk(dev_act_led, 1, "activity lamp");
    chk(pwr_act_line, 0, "power line low");
    cyc(STR + 1);
    chk(dev_act_led, 0, "activity lamp off");
    chk(pwr_act_oe_n, 1, "power line released");
    chk(pwr_act_line, 1, "power line pulled up");
    $display("test act done");
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    rst_n       = 1'b0;
    wp_close    = 1'b0;
    trig_close  = 1'b0;
    link_access = 1'b0;
    cmd_valid   = 1'b0;
    cmd_code    = 8'h00;
    erase_done  = 1'b0;
    starts      = 0;
    mismatches  = 0;
    checks_done = 0;
    cyc(2);
    chk(pwr_act_oe_n, 1, "reset released line");
    @(posedge sys_clk);
    rst_n <= 1'b1;
    cyc(2);
    t_wp();
    t_trig_short();
    t_trig_long();
    t_cmd();
    t_act();
    summarize();
  end

  // the whole run is under two hundred cycles, so this span only trips on a hang
  initial begin
    #20000;
    mismatches++;
    $display("watchdog expired");
    summarize();
  end
endmodule
